//--- common/apc_defs.svh
// constants for the converter output control block
// assumes a 250 MHz system clock and 32-bit avalon-mm registers
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define APC_OFS_CTRL        4'h0
`define APC_OFS_STAT        4'h4
`define APC_CTRL_BYPASS     0
`define APC_CTRL_PWRDN      1
`define APC_CTRL_RST        2'h0
`define APC_STAT_CLKPD      0
`define APC_STAT_SLOW       1
`define APC_STAT_LOOPSLOW   2
`define APC_STAT_PD         3
`define APC_STAT_FMT        4
`define APC_STAT_OEPIN      6

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define APC_CLK_MHZ         250
`define APC_PD_FREQ_KHZ     1000
`define APC_SLOW_FREQ_KHZ   10000
`define APC_LOOP_MIN_KHZ    60000
`define APC_PD_CYC   (`APC_CLK_MHZ * 1000 / `APC_PD_FREQ_KHZ)
`define APC_SLOW_CYC (`APC_CLK_MHZ * 1000 / `APC_SLOW_FREQ_KHZ)
`define APC_LOOP_CYC (`APC_CLK_MHZ * 1000 / `APC_LOOP_MIN_KHZ)
`define APC_CNT_W           9

`endif

//--- common/apc_pkg.sv
// types for the converter output control block
// assumes apc_defs.svh is compiled alongside
`default_nettype none
package apc_pkg;

    typedef struct packed {
        logic        over_range_flag;
        logic [13:0] code;
    } apc_word_type;

    typedef enum logic [1:0] {
        APC_ST_IDLE  = 2'b00,
        APC_ST_SETUP = 2'b01,
        APC_ST_EDGE  = 2'b10
    } apc_state_type;

    typedef struct packed {
        logic twos;
        logic fall;
    } apc_fmt_type;

endpackage
`default_nettype wire

//--- rtl/apc_top.sv
// output control of a 14-bit sampling converter: parallel bus,
// over-range flag, data strobe, format select, clock-loss power-down
// assumes core words and OUT_READY on CLK_SYS; pins and the sample
// clock arrive from outside and are synchronised here
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.svh"

module apc_top
    import apc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SAMPLE_CLK,
    input  wire logic        CORE_VALID,
    input  wire logic [13:0] CORE_CODE,
    output logic             CORE_READY,
    input  wire logic [1:0]  FORMAT_SELECT_PIN,
    input  wire logic        OUTPUT_ENABLE_PIN,
    input  wire logic        OUT_READY,
    output logic      [13:0] DATA_OUT,
    output logic             DATA_OE,
    output logic             OVER_RANGE_FLAG,
    output logic             OUTPUT_SAMPLE_STROBE,
    output logic             LOOP_BYPASS
);

    // --------------------------------------------------------
    // functions
    // --------------------------------------------------------
    function automatic logic full_scale(input logic [13:0] c);
        full_scale = (&c) | ~(|c);
    endfunction

    function automatic logic [13:0] coded(input logic [13:0] c,
                                          input logic twos);
        coded = {c[13] ^ twos, c[12:0]};
    endfunction

    // --------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic       sclk_d_r;
    wire        sclk_s    = pin_s2_r[0];
    wire        oe_pin_s  = pin_s2_r[1];
    apc_fmt_type fmt;
    assign fmt = apc_fmt_type'(pin_s2_r[3:2]);
    wire        sclk_rise = sclk_s & ~sclk_d_r;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            sclk_d_r <= 1'b0;
        end
        else if (CE)
        begin
            pin_s1_r <= {FORMAT_SELECT_PIN, OUTPUT_ENABLE_PIN,
                         SAMPLE_CLK};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= sclk_s;
        end
    end

    // --------------------------------------------------------
    // sample clock watch
    // --------------------------------------------------------
    // period measured in system cycles; one count per cycle
    logic [`APC_CNT_W-1:0] per_cnt_r;
    logic                  clk_pd_r;
    logic                  slow_r;
    logic                  loop_slow_r;
    wire cnt_top  = per_cnt_r == `APC_CNT_W'(`APC_PD_CYC);
    wire is_slow  = per_cnt_r > `APC_CNT_W'(`APC_SLOW_CYC);
    wire loop_lo  = per_cnt_r > `APC_CNT_W'(`APC_LOOP_CYC);

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            per_cnt_r   <= '0;
            clk_pd_r    <= 1'b0;
            slow_r      <= 1'b0;
            loop_slow_r <= 1'b0;
        end
        else if (CE)
        begin
            if (sclk_rise)
            begin
                per_cnt_r   <= '0;
                clk_pd_r    <= 1'b0;
                slow_r      <= is_slow;
                loop_slow_r <= loop_lo;
            end
            else if (cnt_top)
                clk_pd_r    <= 1'b1;
            else
                per_cnt_r   <= per_cnt_r + 1'b1;
        end
    end

    // --------------------------------------------------------
    // register bus
    // --------------------------------------------------------
    logic [1:0] ctrl_r;
    logic       wait_r;
    logic [31:0] rdata_r;
    wire        req      = AVS_READ | AVS_WRITE;
    wire        take     = req & wait_r;
    wire        wr_done  = AVS_WRITE & ~wait_r;
    wire        sel_ctrl = AVS_ADDRESS == `APC_OFS_CTRL;
    wire        sel_stat = AVS_ADDRESS == `APC_OFS_STAT;
    wire        pwr_dn   = ctrl_r[`APC_CTRL_PWRDN] | clk_pd_r;
    wire [31:0] stat_w   = {25'h000_0000, oe_pin_s, fmt, pwr_dn,
                            loop_slow_r, slow_r, clk_pd_r};
    wire [31:0] rd_word  = sel_ctrl ? {30'h0000_0000, ctrl_r} :
                           sel_stat ? stat_w : 32'h0000_0000;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ctrl_r  <= `APC_CTRL_RST;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end
        else if (CE)
        begin
            wait_r <= ~take;
            if (take & AVS_READ)
                rdata_r <= rd_word;
            if (wr_done & sel_ctrl)
                ctrl_r <= AVS_WRITEDATA[1:0];
        end
    end

    // --------------------------------------------------------
    // two-entry buffer
    // --------------------------------------------------------
    apc_word_type buf_mem [2];
    logic       wp_r;
    logic       rp_r;
    logic [1:0] cnt_r;
    apc_state_type st_r;
    apc_state_type st_nxt;
    wire        not_full = cnt_r != 2'd2;
    wire        push     = CORE_VALID & not_full & ~pwr_dn;
    wire        can_pop  = (st_r == APC_ST_IDLE) |
                           ((st_r == APC_ST_EDGE) & OUT_READY);
    wire        pop      = (cnt_r != 2'd0) & can_pop;
    apc_word_type in_word;
    assign in_word = '{over_range_flag: full_scale(CORE_CODE),
                       code: CORE_CODE};
    apc_word_type head;
    assign head = buf_mem[rp_r];

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end
        else if (CE)
        begin
            if (push)
            begin
                buf_mem[wp_r] <= in_word;
                wp_r          <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // --------------------------------------------------------
    // output word and strobe
    // --------------------------------------------------------
    // data changes with the strobe inactive; the active edge
    // follows a cycle later and holds while the receiver stalls
    always_comb
    begin
        unique case (st_r)
            APC_ST_IDLE:  st_nxt = pop ? APC_ST_SETUP : APC_ST_IDLE;
            APC_ST_SETUP: st_nxt = APC_ST_EDGE;
            APC_ST_EDGE:  st_nxt = pop ? APC_ST_SETUP :
                                   OUT_READY ? APC_ST_IDLE :
                                   APC_ST_EDGE;
            default:      st_nxt = APC_ST_IDLE;
        endcase
    end

    wire strobe_nxt = (st_nxt == APC_ST_EDGE) ^ fmt.fall;
    wire oe_nxt     = oe_pin_s & ~pwr_dn;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_r                 <= APC_ST_IDLE;
            DATA_OUT             <= 14'h0000;
            OVER_RANGE_FLAG      <= 1'b0;
            OUTPUT_SAMPLE_STROBE <= 1'b0;
            DATA_OE              <= 1'b0;
            CORE_READY           <= 1'b0;
            LOOP_BYPASS          <= 1'b0;
        end
        else if (CE)
        begin
            st_r                 <= st_nxt;
            OUTPUT_SAMPLE_STROBE <= strobe_nxt;
            DATA_OE              <= oe_nxt;
            CORE_READY           <= cnt_r + {1'b0, push} -
                                    {1'b0, pop} != 2'd2 & ~pwr_dn;
            LOOP_BYPASS          <= ctrl_r[`APC_CTRL_BYPASS];
            if (pop)
            begin
                DATA_OUT        <= coded(head.code, fmt.twos);
                OVER_RANGE_FLAG <= head.over_range_flag;
            end
        end
    end

    assign AVS_READDATA    = rdata_r;
    assign AVS_WAITREQUEST = wait_r;

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    default clocking cb @(posedge CLK_SYS iff CE);
    endclocking
    default disable iff (RST);

    sequence s_setup;
        OUTPUT_SAMPLE_STROBE == fmt.fall;
    endsequence
    sequence s_edge;
        OUTPUT_SAMPLE_STROBE != fmt.fall;
    endsequence

    strobe_edge_a: assert property (
        pop |=> s_setup ##1 s_edge)
        else $error("strobe did not mark new word");
    data_hold_a: assert property (
        pop |=> ##1 $stable(DATA_OUT))
        else $error("data moved at strobe edge");
    twos_code_a: assert property (
        pop |=> DATA_OUT[13] == ($past(head.code[13]) ^ fmt.twos)
                && DATA_OUT[12:0] == $past(head.code[12:0]))
        else $error("output coding wrong");
    over_range_a: assert property (
        pop |=> OVER_RANGE_FLAG == ($past(head.code) == 14'h3fff ||
                                    $past(head.code) == 14'h0000))
        else $error("over-range flag wrong");
    oe_pin_a: assert property (
        !oe_pin_s |=> !DATA_OE)
        else $error("outputs driven with enable low");
    pd_bit_a: assert property (
        ctrl_r[`APC_CTRL_PWRDN] |=> !DATA_OE && !CORE_READY)
        else $error("power-down bit left outputs on");
    clk_loss_a: assert property (
        !sclk_rise && cnt_top |=> clk_pd_r ##1 !DATA_OE)
        else $error("no power-down on clock loss");
    reset_dflt_a: assert property (
        $past(RST) |-> !ctrl_r[`APC_CTRL_BYPASS] && DATA_OUT == 14'h0000)
        else $error("reset defaults wrong");
    bus_answer_a: assert property (
        take |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");
    buf_full_a: assert property (
        cnt_r == 2'd2 |-> !CORE_READY && !push)
        else $error("buffer overfilled");

endmodule
`default_nettype wire

//--- sim/apc_capture_model.sv
// capture logic at the far side of the parallel output bus
// assumes strobe, data and flag are registered on the system clock
`timescale 1ns/1ps
`default_nettype none
module apc_capture_model
    import apc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        fall,
    input  wire logic        stall,
    input  wire logic        strobe,
    input  wire logic        oe,
    input  wire logic [13:0] data,
    input  wire logic        over_range_flag,
    output logic             ready
);
    logic         prev_r;
    logic         edge_hit;
    apc_word_type got[$];

    // ------------------------------------------------------------
    // capture on the selected strobe edge only
    // ------------------------------------------------------------
    assign ready = !stall;
    assign edge_hit = fall ? (prev_r && !strobe)
                           : (!prev_r && strobe);
    always @(posedge clk)
    begin
        prev_r <= strobe;
        if (rst)
            got.delete();
        else if (oe && edge_hit)
            got.push_back({over_range_flag, data});
    end
endmodule
`default_nettype wire

//--- sim/apc_top_test.sv
// self-checking bench for the converter output control block
// assumes apc_pkg and the capture model are compiled first
`timescale 1ns/1ps
`default_nettype none
module apc_top_test
    import apc_pkg::*;
;
    logic         clk_sys = 0, rst = 1, sclk = 0, sclk_run = 1;
    logic         av_rd = 0, av_wr = 0, av_wait, core_valid = 0;
    logic [3:0]   av_addr = 0;
    logic [31:0]  av_wdata = 0, av_rdata, rd_q;
    logic [13:0]  core_code = 0, dout;
    logic [1:0]   fmt = 0;
    logic         oe_pin = 1, out_ready, data_oe, over_range_flag, strobe;
    logic         core_ready, bypass, stall = 0, ce = 1;
    int           n_errors = 0, checks_done = 0, cyc = 0, n;
    int           seed = 32'h7e99;
    apc_word_type exp_q[$];

    always #2 clk_sys = ~clk_sys;
    always #62.5 sclk = sclk_run ? ~sclk : 1'b0;
    always @(posedge clk_sys)
        stall <= $random(seed) & 1;

    apc_top dut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce),
        .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
        .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
        .AVS_WAITREQUEST(av_wait), .SAMPLE_CLK(sclk),
        .CORE_VALID(core_valid), .CORE_CODE(core_code),
        .CORE_READY(core_ready), .FORMAT_SELECT_PIN(fmt),
        .OUTPUT_ENABLE_PIN(oe_pin), .OUT_READY(out_ready),
        .DATA_OUT(dout), .DATA_OE(data_oe), .OVER_RANGE_FLAG(over_range_flag),
        .OUTPUT_SAMPLE_STROBE(strobe), .LOOP_BYPASS(bypass));

    apc_capture_model cap (.clk(clk_sys), .rst(rst), .fall(fmt[0]),
        .stall(stall), .strobe(strobe), .oe(data_oe), .data(dout),
        .over_range_flag(over_range_flag), .ready(out_ready));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        av_addr <= a;
        av_wr <= wr;
        av_rd <= !wr;
        av_wdata <= d;
        @(posedge clk_sys);
        while (av_wait !== 1'b0)
            @(posedge clk_sys);
        rd_q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    function apc_word_type exp_word(input logic [13:0] c, input logic t);
        exp_word.over_range_flag = (c == 14'h3fff) || (c == 14'h0000);
        exp_word.code = t ? {~c[13], c[12:0]} : c;
    endfunction

    task send(input logic [13:0] c);
        core_valid <= 1'b1;
        core_code <= c;
        exp_q.push_back(exp_word(c, fmt[1]));
        @(posedge clk_sys);
        while (core_ready !== 1'b1)
            @(posedge clk_sys);
    endtask

    task end_of_test;
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        for (int f = 0; f < 4; f++)
        begin
            rst <= 1'b1;
            fmt <= f[1:0];
            repeat (f == 0 ? 10 : 500) @(posedge clk_sys);
            chk("data_out_rst", 32'h0000_0000, 32'(dout));
            chk("bypass_rst", 32'h0000_0000, 32'(bypass));
            rst <= 1'b0;
            repeat (6) @(posedge clk_sys);
            chk("strobe_idle", 32'(fmt[0]), 32'(strobe));
            bus(1'b0, 4'h4, 32'h0000_0000);
            chk("status_fmt", 32'(fmt), 32'(rd_q[5:4]));
            send(14'h3fff);
            send(14'h0000);
            send(14'h2000);
            repeat (12) send(14'($random(seed)));
            core_valid <= 1'b0;
            n = 0;
            while (cap.got.size() < exp_q.size() && n < 2000)
            begin
                @(posedge clk_sys);
                n++;
            end
            chk("word_count", exp_q.size(), cap.got.size());
            foreach (exp_q[i])
                chk("word", 32'(exp_q[i]), 32'(cap.got[i]));
            exp_q.delete();
        end
        bus(1'b0, 4'h0, 32'h0000_0000);
        chk("ctrl_rst", 32'h0000_0000, rd_q);
        bus(1'b1, 4'h0, 32'h0000_0001);
        @(posedge clk_sys);
        chk("loop_bypass", 32'h0000_0001, 32'(bypass));
        bus(1'b0, 4'h0, 32'h0000_0000);
        chk("ctrl_back", 32'h0000_0001, rd_q);
        bus(1'b1, 4'h8, 32'h0000_0003);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd_q);
        oe_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("oe_low", 32'h0000_0000, 32'(data_oe));
        oe_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("oe_high", 32'h0000_0001, 32'(data_oe));
        bus(1'b1, 4'h0, 32'h0000_0002);
        repeat (3) @(posedge clk_sys);
        chk("pd_oe", 32'h0000_0000, 32'(data_oe));
        chk("pd_ready", 32'h0000_0000, 32'(core_ready));
        bus(1'b1, 4'h0, 32'h0000_0000);
        sclk_run <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk("lost_oe", 32'h0000_0000, 32'(data_oe));
        bus(1'b0, 4'h4, 32'h0000_0000);
        chk("lost_flag", 32'h0000_0001, 32'(rd_q[0]));
        chk("lost_stat", 32'h0000_000f, 32'(rd_q[3:0]));
        sclk_run <= 1'b1;
        repeat (100) @(posedge clk_sys);
        chk("back_oe", 32'h0000_0001, 32'(data_oe));
        ce <= 1'b0;
        oe_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("ce_hold", 32'h0000_0001, 32'(data_oe));
        ce <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("ce_run", 32'h0000_0000, 32'(data_oe));
        end_of_test;
    end
endmodule
`default_nettype wire
